// File: bench/sfs_peer_model.sv
// Peer model: drives frames on the receive line and times the send line
`default_nettype none
module sfs_peer_model (
  input wire logic sys_clk,
  input wire logic send,
  input wire logic watch,
  input wire logic [3:0] n_per,
  input wire logic [7:0] per [0:8],
  input wire logic line_in,
  output logic line_out,
  output logic busy,
  output logic [7:0] seen,
  output logic seen_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b1;
  logic armed = 1'b0;
  int cnt = 0;
  initial begin
    line_out = 1'b1;
    busy = 1'b0;
    seen_vld = 1'b0;
    seen = 8'h00;
  end
  // ==========================================
  // Frame driver
  // Each slot is 5 clocks low then high; a last fall closes the final slot
  always begin
    @(posedge sys_clk);
    if (send) begin
      busy <= 1'b1;
      for (int i = 0; i <= n_per; i++) begin
        line_out <= 1'b0;
        repeat (5) @(posedge sys_clk);
        line_out <= 1'b1;
        if (i < n_per) repeat (per[i] - 5) @(posedge sys_clk);
      end
      busy <= 1'b0;
    end
  end
  // ==========================================
  // Send line timer
  // Gaps longer than a sync are idle time between frames, not slots
  always @(posedge sys_clk) begin
    seen_vld <= 1'b0;
    prev <= line_in;
    cnt <= cnt + 1;
    if (!watch) armed <= 1'b0;
    if (prev && !line_in) begin
      cnt <= 1;
      armed <= 1'b1;
      seen <= 8'(cnt);
      seen_vld <= armed && watch && cnt <= 56;
    end
  end
endmodule : sfs_peer_model
`default_nettype wire

// File: bench/tb_sent_frame_status_data.sv
// Self-checking bench of the frame status and data block
`default_nettype none
module tb_sent_frame_status_data;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] d; logic [15:0] m;} sfs_exp_s;
  localparam logic [7:0] CTL = sfs_pkg::ADDR_CTRL;
  localparam logic [7:0] STA = sfs_pkg::ADDR_STAT;
  localparam logic [7:0] DL = sfs_pkg::ADDR_DATL;
  localparam logic [7:0] DH = sfs_pkg::ADDR_DATH;
  localparam logic [7:0] RST_ADR [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
  localparam logic WR = 1'b1;
  localparam logic RD = 1'b0;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sent_rx_in, sent_tx_out, busy, seen_vld;
  logic send = 1'b0;
  logic watch = 1'b0;
  logic [3:0] n_per = 4'h0;
  logic [7:0] per [0:8];
  logic [7:0] seen;
  logic [7:0] lfsr = 8'h4F;
  logic [15:0] q;
  int n_errors = 0;
  int check_count = 0;
  sfs_exp_s rd_q [$];
  logic [7:0] per_q [$];
  sfs_exp_s e;
  always #2.5 sys_clk = ~sys_clk;
  sfs_top #(.PAUSE_TICKS(16'h0010)) uut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sent_rx_in(sent_rx_in), .sent_tx_out(sent_tx_out));
  sfs_peer_model peer (.sys_clk(sys_clk), .send(send), .watch(watch), .n_per(n_per), .per(per),
    .line_in(sent_tx_out), .line_out(sent_rx_in), .busy(busy), .seen(seen), .seen_vld(seen_vld));
  // ==========================================
  // Compare and reference helpers
  task automatic report(input string what, input logic [15:0] x, input logic [15:0] y);
    check_count++;
    if (x !== y) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, x, y);
    end
  endtask : report
  task automatic check_reg(input logic [15:0] x, input logic [15:0] y);
    report("register read", x, y);
  endtask : check_reg
  task automatic check_period(input logic [7:0] x, input logic [7:0] y);
    report("line period", {8'h00, x}, {8'h00, y});
  endtask : check_period
  function automatic logic [15:0] rnd16();
    for (int i = 0; i < 2; i++) begin
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      rnd16 = {rnd16[7:0], lfsr};
    end
  endfunction : rnd16
  function automatic logic [3:0] crc_of(input logic [23:0] d, input int n);
    logic [3:0] c;
    c = sfs_pkg::CRC_SEED;
    for (int i = 0; i <= n; i++) begin
      for (int k = 0; k < 4; k++) c = c[3] ? {c[2:0], 1'b0} ^ sfs_pkg::CRC_POLY : {c[2:0], 1'b0};
      if (i < n) c = c ^ d[23 - 4 * i -: 4];
    end
    return c;
  endfunction : crc_of
  // ==========================================
  // Bus master and frame tasks
  // Reads note their expectation before the request; mask 0 marks a poll
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [15:0] m);
    if (!w) rd_q.push_back({d, m});
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic frame(input logic mid);
    int n;
    n = 0;
    @(posedge sys_clk);
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    if (mid) begin
      repeat (100) @(posedge sys_clk);
      wb(STA, RD, 16'h0001, 16'h0003);
      wb(STA, WR, 16'h0000, 16'h0000);
      wb(STA, RD, 16'h0001, 16'h0001);
    end
    do begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    repeat (4) @(posedge sys_clk);
  endtask : frame
  task automatic rx_frame(input logic bad, input logic err);
    logic [31:0] w;
    logic [3:0] c;
    w = {rnd16(), rnd16()};
    c = crc_of(w[27:4], 6) ^ {3'b000, bad};
    per[0] = 8'h38;
    for (int k = 0; k < 7; k++) per[k + 1] = 8'h0C + w[31 - 4 * k -: 4];
    per[8] = 8'h0C + c;
    n_per = 4'h9;
    frame(1'b1);
    wb(DH, WR, ~w[31:16], 16'h0000);
    wb(DL, WR, ~w[15:0], 16'h0000);
    wb(DH, RD, w[31:16], 16'hFFFF);
    wb(DL, RD, {w[15:4], c}, 16'hFFFF);
    wb(STA, RD, {12'h000, err, 3'b000}, 16'h00F9);
  endtask : rx_frame
  task automatic tx_frame(input logic [2:0] n);
    logic [15:0] dh, dl;
    logic [23:0] d;
    logic [3:0] c;
    int k;
    dh = rnd16();
    dl = rnd16();
    d = {dh[11:0], dl[15:4]};
    c = crc_of(d, n);
    wb(CTL, WR, 16'h0000, 16'h0000);
    wb(DH, WR, dh, 16'h0000);
    wb(DL, WR, dl, 16'h0000);
    per_q = '{8'h38, 8'h0C + dh[15:12]};
    for (k = 0; k < n; k++) per_q.push_back(8'h0C + d[23 - 4 * k -: 4]);
    per_q.push_back(8'h0C + c);
    watch <= 1'b1;
    wb(CTL, WR, 16'h8580 | {13'h0000, n}, 16'h0000);
    wb(STA, WR, 16'h0001, 16'h0000);
    wb(STA, RD, 16'h0001, 16'h0001);
    k = 0;
    do begin
      wb(STA, RD, 16'h0000, 16'h0000);
      k++;
    end while (q[0] !== 1'b0 && k < 200);
    wb(STA, RD, 16'h0000, 16'h0001);
    watch <= 1'b0;
    check_period(8'h00, 8'(per_q.size()));
    if (n == 6) wb(DL, RD, {dl[15:4], c}, 16'hFFFF);
  endtask : tx_frame
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // ==========================================
  // Result watcher and watchdog
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      if (e.m !== 16'h0000) check_reg(e.d & e.m, wb_dat_o[15:0] & e.m);
    end
    if (seen_vld === 1'b1) check_period(per_q.size() > 0 ? per_q.pop_front() : 8'hFF, seen);
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_sim();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (RST_ADR[i]) wb(RST_ADR[i], RD, 16'h0000, 16'hFFFF);
    $display("test reset values done");
    wb(sfs_pkg::ADDR_TICK, WR, 16'h0000, 16'h0000);
    for (int n = 1; n <= 6; n++) tx_frame(3'(n));
    $display("test triggered send done");
    wb(CTL, WR, 16'h8186, 16'h0000);
    repeat (20) @(posedge sys_clk);
    wb(STA, RD, 16'h0001, 16'h0001);
    wb(CTL, WR, 16'h0186, 16'h0000);
    wb(STA, RD, 16'h0000, 16'h0001);
    $display("test continuous send done");
    wb(sfs_pkg::ADDR_SMAX, WR, 16'h0043, 16'h0000);
    wb(sfs_pkg::ADDR_SMIN, WR, 16'h002D, 16'h0000);
    wb(CTL, WR, 16'h8906, 16'h0000);
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b1);
    repeat (80) @(posedge sys_clk);
    wb(STA, RD, 16'h0002, 16'h0002);
    foreach (RST_ADR[i]) if (i < 2) begin
      per[0] = 8'h38;
      per[1] = 8'h0C;
      per[2] = (i == 0) ? 8'h0B : 8'h1C;
      n_per = 4'h3;
      frame(1'b0);
      wb(STA, RD, 16'h0014, 16'h0075);
      wb(STA, WR, 16'h0000, 16'h0000);
      wb(STA, RD, 16'h0000, 16'h0004);
    end
    rx_frame(1'b0, 1'b0);
    wb(CTL, WR, 16'h8806, 16'h0000);
    rx_frame(1'b1, 1'b0);
    $display("test receive done");
    end_sim();
  end
endmodule : tb_sent_frame_status_data
`default_nettype wire

// File: src/sfs_crc4.sv
// Four-bit frame check over up to six data nibbles, zero-augmented
`default_nettype none
module sfs_crc4 (
  input wire logic [23:0] nibs,
  input wire logic [2:0] count,
  output logic [3:0] crc
);
  function automatic logic [3:0] step(input logic [3:0] c, input logic [3:0] d);
    logic [3:0] r;
    r = c;
    // Multiply by x^4 modulo the generator, then add the nibble in at the bottom
    for (int b = 0; b < 4; b++) begin
      r = r[3] ? ({r[2:0], 1'b0} ^ sfs_pkg::CRC_POLY) : {r[2:0], 1'b0};
    end
    return r ^ d;
  endfunction : step

  always_comb begin
    logic [3:0] acc;
    acc = sfs_pkg::CRC_SEED;
    for (int i = 0; i < 6; i++) begin
      if (i < int'(count)) begin
        acc = step(acc, nibs[23 - 4 * i -: 4]);
      end
    end
    // Trailing zero nibble gives the preferred method
    crc = step(acc, 4'h0);
  end
endmodule : sfs_crc4
`default_nettype wire

// File: src/sfs_pkg.sv
// Shared constants, types and helpers of the frame status and data block
`default_nettype none
package sfs_pkg;
  // ==========================================
  // Register offsets on the Wishbone bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATL = 8'h08;
  localparam logic [7:0] ADDR_DATH = 8'h0C;
  localparam logic [7:0] ADDR_TICK = 8'h10;
  localparam logic [7:0] ADDR_SMAX = 8'h14;
  localparam logic [7:0] ADDR_SMIN = 8'h18;
  // ==========================================
  // Field positions and reset values
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_RX_BIT = 11;
  localparam int CTRL_TXM_BIT = 10;
  localparam int CTRL_CHK_BIT = 8;
  localparam int CTRL_PPP_BIT = 7;
  localparam logic [15:0] CTRL_RW_MASK = 16'h8D87;
  localparam int STAT_FRM_BIT = 2;
  localparam int STAT_SYNC_BIT = 0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ==========================================
  // Frame timing in ticks, check seed and polynomial, check nibble position
  localparam logic [15:0] NIB_MIN_TICKS = 16'h000C;
  localparam logic [15:0] NIB_MAX_TICKS = 16'h001B;
  localparam logic [15:0] SYNC_TICKS = 16'h0038;
  localparam logic [15:0] LOW_TICKS = 16'h0005;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;
  localparam logic [2:0] POS_CRC = 3'h7;
  // ==========================================
  // State types
  typedef enum logic [1:0] {R_HUNT, R_NIB, R_PAUSE} sfs_rx_e;
  typedef enum logic [1:0] {T_IDLE, T_SYNC, T_NIB, T_PAUSE} sfs_tx_e;
  // Reserved count codes fall back to a single nibble
  function automatic logic [2:0] nib_limit(input logic [2:0] code);
    return (code == 3'h0 || code == 3'h7) ? 3'h1 : code;
  endfunction : nib_limit
  // Status nibble, data nibbles up to the limit, then the check nibble
  function automatic logic [2:0] next_pos(input logic [2:0] pos, input logic [2:0] lim);
    if (pos == lim && pos != 3'h0) begin
      return POS_CRC;
    end
    return pos + 3'h1;
  endfunction : next_pos
endpackage : sfs_pkg
`default_nettype wire

// File: src/sfs_tick.sv
// Tick generator: one pulse every div+1 clocks, realignable
`default_nettype none
module sfs_tick #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (reset || restart || cnt_reg == div) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Decoded from the counter so the first tick after a realign is not a clock late
  assign tick = !reset && !restart && cnt_reg == div;
endmodule : sfs_tick
`default_nettype wire

// File: src/sfs_top.sv
// Single-wire frame link: status, nibble tracking and data registers
`default_nettype none
module sfs_top #(
  parameter logic [15:0] PAUSE_TICKS = 16'h0040,
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sent_rx_in,
  output logic sent_tx_out
);
  // ==========================================
  // Register state
  logic [15:0] link_control_one_reg, frame_data_low_reg, frame_data_high_reg;
  logic [15:0] tick_div_reg, sync_max_reg, sync_min_reg;
  logic framing_error_flag_reg, check_error_flag_reg, rx_sync_reg, tx_start_reg;
  logic [2:0] rx_pos_reg, tx_pos_reg;
  logic [CNT_W-1:0] per_cnt_reg, idle_cnt_reg, sym_cnt_reg;
  logic [31:0] shadow_reg;
  logic rx_prev_reg;
  sfs_pkg::sfs_rx_e rx_st_reg, rx_st_next;
  sfs_pkg::sfs_tx_e tx_st_reg, tx_st_next;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // ==========================================
  // Control decode
  wire module_enable = link_control_one_reg[sfs_pkg::CTRL_EN_BIT];
  wire receive_role_sel = link_control_one_reg[sfs_pkg::CTRL_RX_BIT];
  wire triggered_tx_sel = link_control_one_reg[sfs_pkg::CTRL_TXM_BIT];
  wire check_enable = link_control_one_reg[sfs_pkg::CTRL_CHK_BIT];
  wire pause_present_sel = link_control_one_reg[sfs_pkg::CTRL_PPP_BIT];
  wire [2:0] nib_lim = sfs_pkg::nib_limit(link_control_one_reg[2:0]);
  wire rx_act = module_enable && receive_role_sel;
  wire tx_act = module_enable && !receive_role_sel;

  // ==========================================
  // Bus decode
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = wb_req && wb_we_i;
  wire hit_ctrl = wb_adr_i == sfs_pkg::ADDR_CTRL;
  wire hit_stat = wb_adr_i == sfs_pkg::ADDR_STAT;
  wire hit_datl = wb_adr_i == sfs_pkg::ADDR_DATL;
  wire hit_dath = wb_adr_i == sfs_pkg::ADDR_DATH;
  wire hit_tick = wb_adr_i == sfs_pkg::ADDR_TICK;
  wire hit_smax = wb_adr_i == sfs_pkg::ADDR_SMAX;
  wire hit_smin = wb_adr_i == sfs_pkg::ADDR_SMIN;
  wire stat_wr = wr && hit_stat && wb_sel_i[0];

  // ==========================================
  // Tick timing and nibble slots
  logic tick;
  wire fall = rx_prev_reg && !sent_rx_in;
  // Realign on each falling edge in the receiver role so periods are counted from the edge
  wire tick_restart = !module_enable || (rx_act ? fall : tx_st_reg == sfs_pkg::T_IDLE);
  sfs_tick #(.W(16)) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .restart(tick_restart),
    .div(tick_div_reg),
    .tick(tick)
  );

  // nibble slot p lives at word bits 31-4p
  wire [31:0] data_word = {frame_data_high_reg, frame_data_low_reg};
  wire [3:0] slot [8];
  wire [CNT_W-1:0] nib_diff = per_cnt_reg - CNT_W'(sfs_pkg::NIB_MIN_TICKS);
  wire [3:0] rx_val = nib_diff[3:0];
  wire nib_bad = per_cnt_reg < CNT_W'(sfs_pkg::NIB_MIN_TICKS) || per_cnt_reg > CNT_W'(sfs_pkg::NIB_MAX_TICKS);
  wire rx_in_nib = rx_act && fall && rx_st_reg == sfs_pkg::R_NIB;
  wire rx_good = rx_in_nib && !nib_bad;
  wire rx_frm_evt = rx_in_nib && nib_bad;
  wire rx_commit = rx_good && rx_pos_reg == sfs_pkg::POS_CRC;
  wire sync_ok = per_cnt_reg >= CNT_W'(sync_min_reg) && per_cnt_reg <= CNT_W'(sync_max_reg);

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_slot
      assign slot[g] = data_word[31 - 4 * g -: 4];
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          shadow_reg[31 - 4 * g -: 4] <= 4'h0;
        end else if (rx_good && rx_pos_reg == 3'(g)) begin
          shadow_reg[31 - 4 * g -: 4] <= rx_val;
        end
      end
    end
  endgenerate

  // ==========================================
  // Check generation
  logic [3:0] crc_rx, crc_tx;
  sfs_crc4 u_crc_rx (.nibs(shadow_reg[27:4]), .count(nib_lim), .crc(crc_rx));
  sfs_crc4 u_crc_tx (.nibs(data_word[27:4]), .count(nib_lim), .crc(crc_tx));

  // ==========================================
  // Receiver
  always_comb begin
    rx_st_next = rx_st_reg;
    case (rx_st_reg)
      sfs_pkg::R_HUNT: if (fall && sync_ok) rx_st_next = sfs_pkg::R_NIB;
      sfs_pkg::R_NIB: if (rx_frm_evt) rx_st_next = sfs_pkg::R_HUNT;
        else if (rx_commit) rx_st_next = pause_present_sel ? sfs_pkg::R_PAUSE : sfs_pkg::R_HUNT;
      sfs_pkg::R_PAUSE: if (fall) rx_st_next = sfs_pkg::R_HUNT;
      default: rx_st_next = sfs_pkg::R_HUNT;
    endcase
    if (!rx_act) rx_st_next = sfs_pkg::R_HUNT;
  end
  wire sync_found = rx_act && fall && rx_st_reg == sfs_pkg::R_HUNT && sync_ok;

  always_ff @(posedge sys_clk) begin
    rx_prev_reg <= reset ? 1'b1 : sent_rx_in;
    rx_st_reg <= reset ? sfs_pkg::R_HUNT : rx_st_next;
    // The clock that sees the edge is already the first of the new period
    if (reset) per_cnt_reg <= '0;
    else if (fall) per_cnt_reg <= CNT_W'(1);
    else if (tick && !(&per_cnt_reg)) per_cnt_reg <= per_cnt_reg + 1'b1;
    if (reset || !rx_act || !sent_rx_in) idle_cnt_reg <= '0;
    else if (tick && !(&idle_cnt_reg)) idle_cnt_reg <= idle_cnt_reg + 1'b1;
  end

  // position advances on good nibbles, holds on error
  always_ff @(posedge sys_clk) begin
    if (reset || !rx_act || sync_found || rx_commit) rx_pos_reg <= 3'h0;
    else if (rx_good) rx_pos_reg <= sfs_pkg::next_pos(rx_pos_reg, nib_lim);
  end

  // sync bit driven by hardware only
  always_ff @(posedge sys_clk) begin
    if (reset || !rx_act || rx_frm_evt || rx_commit) rx_sync_reg <= 1'b0;
    else if (sync_found) rx_sync_reg <= 1'b1;
  end

  // sticky, set wins over software clear by writing zero
  always_ff @(posedge sys_clk) begin
    if (reset) framing_error_flag_reg <= 1'b0;
    else if (rx_frm_evt) framing_error_flag_reg <= 1'b1;
    else if (stat_wr && !wb_dat_i[sfs_pkg::STAT_FRM_BIT]) framing_error_flag_reg <= 1'b0;
  end

  // verdict refreshed on every completed frame
  always_ff @(posedge sys_clk) begin
    if (reset) check_error_flag_reg <= 1'b0;
    else if (rx_commit) check_error_flag_reg <= check_enable && crc_rx != rx_val;
  end

  // ==========================================
  // Transmitter
  logic [CNT_W-1:0] sym_len;
  assign sym_len = tx_st_reg == sfs_pkg::T_SYNC ? CNT_W'(sfs_pkg::SYNC_TICKS) :
    tx_st_reg == sfs_pkg::T_PAUSE ? CNT_W'(PAUSE_TICKS) :
    CNT_W'(sfs_pkg::NIB_MIN_TICKS) + CNT_W'(slot[tx_pos_reg]);
  wire sym_end = tick && sym_cnt_reg == sym_len - 1'b1;
  wire tx_go = tx_act && (!triggered_tx_sel || tx_start_reg);
  wire crc_end = sym_end && tx_st_reg == sfs_pkg::T_NIB && tx_pos_reg == sfs_pkg::POS_CRC;
  wire frame_done = (crc_end && !pause_present_sel) || (sym_end && tx_st_reg == sfs_pkg::T_PAUSE);

  // continuous frames run back to back, triggered ones stop
  always_comb begin
    tx_st_next = tx_st_reg;
    case (tx_st_reg)
      sfs_pkg::T_IDLE: if (tx_go) tx_st_next = sfs_pkg::T_SYNC;
      sfs_pkg::T_SYNC: if (sym_end) tx_st_next = sfs_pkg::T_NIB;
      sfs_pkg::T_NIB: if (crc_end && pause_present_sel) tx_st_next = sfs_pkg::T_PAUSE;
      sfs_pkg::T_PAUSE: tx_st_next = tx_st_reg;
      default: tx_st_next = sfs_pkg::T_IDLE;
    endcase
    if (frame_done) tx_st_next = triggered_tx_sel ? sfs_pkg::T_IDLE : sfs_pkg::T_SYNC;
    if (!tx_act) tx_st_next = sfs_pkg::T_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    tx_st_reg <= reset ? sfs_pkg::T_IDLE : tx_st_next;
    if (reset || tx_st_reg == sfs_pkg::T_IDLE || sym_end) sym_cnt_reg <= '0;
    else if (tick) sym_cnt_reg <= sym_cnt_reg + 1'b1;
    if (reset || tx_st_reg != sfs_pkg::T_NIB) tx_pos_reg <= 3'h0;
    else if (sym_end) tx_pos_reg <= sfs_pkg::next_pos(tx_pos_reg, nib_lim);
    // Each symbol opens with a fixed low pulse; idle line stays high
    sent_tx_out <= reset || tx_st_reg == sfs_pkg::T_IDLE || sym_cnt_reg >= CNT_W'(sfs_pkg::LOW_TICKS);
  end

  // set only while clear, held through the frame, cleared after
  always_ff @(posedge sys_clk) begin
    if (reset || !tx_act || !triggered_tx_sel || frame_done) tx_start_reg <= 1'b0;
    else if (stat_wr && wb_dat_i[sfs_pkg::STAT_SYNC_BIT]) tx_start_reg <= 1'b1;
  end

  // ==========================================
  // Register writes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link_control_one_reg <= sfs_pkg::REG_RESET;
      tick_div_reg <= sfs_pkg::REG_RESET;
      sync_max_reg <= sfs_pkg::REG_RESET;
      sync_min_reg <= sfs_pkg::REG_RESET;
    end else if (wr) begin
      if (hit_ctrl) link_control_one_reg <= merge(link_control_one_reg, wb_dat_i, wb_sel_i) & sfs_pkg::CTRL_RW_MASK;
      if (hit_tick) tick_div_reg <= merge(tick_div_reg, wb_dat_i, wb_sel_i);
      if (hit_smax) sync_max_reg <= merge(sync_max_reg, wb_dat_i, wb_sel_i);
      if (hit_smin) sync_min_reg <= merge(sync_min_reg, wb_dat_i, wb_sel_i);
    end
  end

  // receiver role: frames are the only writer
  wire dat_sw = wr && !receive_role_sel;
  wire [15:0] datl_sw = merge(frame_data_low_reg, wb_dat_i, wb_sel_i);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_data_low_reg <= sfs_pkg::REG_RESET;
      frame_data_high_reg <= sfs_pkg::REG_RESET;
    end else if (receive_role_sel) begin
      if (rx_commit) {frame_data_high_reg, frame_data_low_reg} <= {shadow_reg[31:4], rx_val};
    end else begin
      if (dat_sw && hit_dath) frame_data_high_reg <= merge(frame_data_high_reg, wb_dat_i, wb_sel_i);
      if (dat_sw && hit_datl) frame_data_low_reg[15:4] <= datl_sw[15:4];
      // hardware owns the check field when auto check is on
      if (check_enable) frame_data_low_reg[3:0] <= crc_tx;
      else if (dat_sw && hit_datl) frame_data_low_reg[3:0] <= datl_sw[3:0];
    end
  end

  // ==========================================
  // Status and read-back
  // pause indicator
  wire pause_flag = (rx_act && rx_st_reg == sfs_pkg::R_PAUSE) || (tx_act && tx_st_reg == sfs_pkg::T_PAUSE);
  wire [2:0] nibble_position = receive_role_sel ? rx_pos_reg : tx_pos_reg;
  wire receiver_idle_flag = rx_act && sent_rx_in && idle_cnt_reg >= CNT_W'(sync_max_reg);
  wire sync_or_tx_start_bit = receive_role_sel ? rx_sync_reg : triggered_tx_sel ? tx_start_reg : module_enable;
  wire [15:0] link_status = {8'h00, pause_flag, nibble_position, check_error_flag_reg,
    framing_error_flag_reg, receiver_idle_flag, sync_or_tx_start_bit};
  wire [15:0] rd_mux = hit_ctrl ? link_control_one_reg : hit_stat ? link_status :
    hit_datl ? frame_data_low_reg : hit_dath ? frame_data_high_reg : hit_tick ? tick_div_reg :
    hit_smax ? sync_max_reg : hit_smin ? sync_min_reg : 16'h0000;

  always_ff @(posedge sys_clk) begin
    wb_ack_o <= !reset && wb_req;
    if (reset) wb_dat_o <= 32'h0000_0000;
    else if (wb_req) wb_dat_o <= {16'h0000, rd_mux};
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_timing: assert property (s_req |=> s_ack_once) else $error("ack not a single pulse after request");
  a_nib_limit: assert property (nib_lim >= 3'h1 && nib_lim <= 3'h6) else $error("nibble limit out of range");
  a_pause_flag: assert property (!pause_flag |-> !(tx_act && tx_st_reg == sfs_pkg::T_PAUSE)) else $error("pause flag low in pause");
  a_tx_pos_zero: assert property (tx_act && tx_st_reg != sfs_pkg::T_NIB |=> tx_pos_reg == 3'h0) else $error("tx position not zero");
  a_rx_pos_hold: assert property (rx_frm_evt |=> rx_pos_reg == $past(rx_pos_reg)) else $error("rx position lost on error");
  a_frm_sets: assert property (rx_frm_evt |=> framing_error_flag_reg && !rx_sync_reg) else $error("framing error not flagged");
  a_sync_hunt: assert property (rx_frm_evt |=> rx_st_reg == sfs_pkg::R_HUNT) else $error("no return to hunting");
  a_cont_sync: assert property (tx_act && !triggered_tx_sel |-> link_status[0]) else $error("continuous sync bit low");
  a_trig_hold: assert property (tx_start_reg && !frame_done && tx_act && triggered_tx_sel |=> tx_start_reg) else $error("start bit dropped");
  a_rx_ro_data: assert property (receive_role_sel && !rx_commit |=> $stable(frame_data_high_reg)) else $error("rx data written");
  a_auto_crc: assert property (!receive_role_sel && check_enable ##1 !receive_role_sel && check_enable && $stable(data_word[31:4])
    |-> frame_data_low_reg[3:0] == crc_tx) else $error("check field not filled");
  a_crc_clear: assert property (rx_commit && !check_enable |=> !check_error_flag_reg) else $error("check error without check");
  a_stat_upper: assert property (link_status[15:8] == 8'h00) else $error("status upper byte set");
endmodule : sfs_top
`default_nettype wire
